// ---- logic/bkr_pkg.sv ----
package bkr_pkg;
  localparam int CLK_MHZ = 100;
  localparam int NUM_CONV = 3;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 24;
  localparam int US_PER_MS = 1000;
  localparam int DLY_STEP_MS = 2;
  localparam int MS_CYCLES = US_PER_MS * CLK_MHZ;
  localparam int SS_TIME_US = 400;
  localparam int SS_STEPS_LOG2 = 6;
  localparam int SS_STEPS = 1 << SS_STEPS_LOG2;
  localparam int SS_CYCLES = SS_TIME_US * CLK_MHZ;
  localparam int SS_STEP_CYCLES = SS_CYCLES / SS_STEPS;

  localparam logic [1:0] REG_CODE = 2'h0;
  localparam logic [1:0] REG_CFG = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  localparam int CFG_RUN = 0;
  localparam int CFG_MODE = 1;
  localparam int CFG_DLY_LSB = 2;
  localparam int CFG_UNMASK = 5;
  localparam int STAT_PG = 0;
  localparam int STAT_ALERT = 1;
  localparam int STAT_ON = 2;

  localparam logic [5:0] RST_CODE = 6'h00;
  localparam logic RST_RUN = 1'b0;
  localparam logic RST_MODE = 1'b0;
  localparam logic [2:0] RST_DLY = 3'h0;
  localparam logic RST_UNMASK = 1'b0;

  localparam logic [7:0][11:0] RANGE_BASE_MV = {12'hC80, 12'h960, 12'h7D0, 12'h640,
                                                12'h4B0, 12'h3E8, 12'h320, 12'h258};
  localparam logic [7:0][6:0] RANGE_STEP_MV = {7'h64, 7'h64, 7'h32, 7'h32, 7'h32, 7'h19, 7'h19, 7'h19};

  typedef enum logic [1:0] {BKR_OFF, BKR_DELAY, BKR_RAMP, BKR_ON} bkr_phase_t;

  typedef struct packed {
    logic below_pg;
    logic light_load;
    logic dropout;
  } bkr_sense_t;

  typedef struct packed {
    logic power_on;
    logic pwm_forced;
    logic light_save;
    logic high_side_hold;
    logic [11:0] target_mv;
  } bkr_conv_out_t;

  typedef struct packed {
    logic run;
    logic mode;
    logic [2:0] dly;
    logic unmask;
    logic [5:0] code;
    bkr_phase_t phase;
    logic [CNT_W-1:0] tick;
    logic [7:0] ms_cnt;
    logic [SS_STEPS_LOG2:0] frac;
    logic pg;
    logic alert;
    bkr_conv_out_t out;
  } bkr_conv_t;

  typedef struct packed {
    bkr_conv_t [NUM_CONV-1:0] conv;
    logic [DATA_W-1:0] rdata;
    logic alert_n;
  } bkr_state_t;

  function automatic logic [11:0] bkr_code_mv(input logic [5:0] code);
    bkr_code_mv = RANGE_BASE_MV[code[5:3]] + ({5'h00, RANGE_STEP_MV[code[5:3]]} * {9'h000, code[2:0]});
  endfunction

  function automatic logic [7:0] bkr_delay_ms(input logic [2:0] dly);
    bkr_delay_ms = (dly == 3'h0) ? 8'h00 : 8'(DLY_STEP_MS << (dly - 3'h1));
  endfunction
endpackage

// ---- logic/bkr_ctrl.sv ----
// Operation
// - Run bit written 1 enables a converter, 0 disables it, each independently.
// - Each converter has a three-bit turn-on delay field applied before startup.
// - Delay code 0 gives 0 ms, else 2 ms doubling per step up to 128 ms.
// - Mode 0 allows light-load power saving; mode 1 forces fixed-frequency PWM always.
// - Readable power-good flag is 0 while output sits below threshold, else 1.
// - Unmasked converter falling below threshold drives the active-low alert output low.
// - Alert stays asserted until host reads that converter's power-good status.
// - Six-bit level code decodes as range base plus step in millivolts.
// - On enable the target follows a monotonic 400 us soft-start ramp.
// - Duty may reach 100 percent, high-side switch held on in dropout.
module bkr_ctrl #(
  parameter int MS_CYCLES = bkr_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [bkr_pkg::ADDR_W-1:0] addr,
  input wire logic [bkr_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [bkr_pkg::DATA_W-1:0] rdata,
  // Converter sense and control
  input wire bkr_pkg::bkr_sense_t [bkr_pkg::NUM_CONV-1:0] sense,
  output bkr_pkg::bkr_conv_out_t [bkr_pkg::NUM_CONV-1:0] conv_out,
  // Host alert
  output logic host_alert_n
);
  import bkr_pkg::*;

  bkr_state_t r;
  bkr_state_t next_r;
  logic [1:0] sel;
  logic hit;
  logic [18:0] prod;
  logic [11:0] final_mv;
  logic any_alert;

  assign rdata = r.rdata;
  assign host_alert_n = r.alert_n;
  always_comb begin
    for (int k = 0; k < NUM_CONV; k++) begin
      conv_out[k] = r.conv[k].out;
    end
  end

  always_comb begin
    next_r = r;
    prod = '0;
    final_mv = '0;
    any_alert = 1'b0;
    sel = addr[3:2];
    hit = (sel < 2'(NUM_CONV));
    next_r.rdata = '0;
    for (int i = 0; i < NUM_CONV; i++) begin
      if (wr && hit && sel == 2'(i)) begin
        unique case (addr[1:0])
          REG_CODE: next_r.conv[i].code = wdata[5:0];
          REG_CFG: begin
            next_r.conv[i].run = wdata[CFG_RUN];
            next_r.conv[i].mode = wdata[CFG_MODE];
            next_r.conv[i].dly = wdata[CFG_DLY_LSB +: 3];
            next_r.conv[i].unmask = wdata[CFG_UNMASK];
          end
          default: ;
        endcase
      end
      if (rd && hit && sel == 2'(i)) begin
        unique case (addr[1:0])
          REG_CODE: next_r.rdata = {2'h0, r.conv[i].code};
          REG_CFG: next_r.rdata = {2'h0, r.conv[i].unmask, r.conv[i].dly, r.conv[i].mode, r.conv[i].run};
          REG_STAT: begin
            next_r.rdata[STAT_PG] = r.conv[i].pg;
            next_r.rdata[STAT_ALERT] = r.conv[i].alert;
            next_r.rdata[STAT_ON] = r.conv[i].out.power_on;
            next_r.conv[i].alert = 1'b0;
          end
          default: ;
        endcase
      end
      next_r.conv[i].pg = ~sense[i].below_pg;
      // alert set after clear so a new fault wins
      if (r.conv[i].unmask && sense[i].below_pg) begin
        next_r.conv[i].alert = 1'b1;
      end
      unique case (r.conv[i].phase)
        BKR_OFF: begin
          if (r.conv[i].run) begin
            next_r.conv[i].tick = '0;
            next_r.conv[i].ms_cnt = '0;
            next_r.conv[i].frac = '0;
            next_r.conv[i].phase = (r.conv[i].dly == 3'h0) ? BKR_RAMP : BKR_DELAY;
          end
        end
        BKR_DELAY: begin
          if (r.conv[i].tick == CNT_W'(MS_CYCLES - 1)) begin
            next_r.conv[i].tick = '0;
            next_r.conv[i].ms_cnt = r.conv[i].ms_cnt + 8'h01;
            // A shorter delay written in mid-count must still end the wait, so the test is not an equality.
            if (r.conv[i].ms_cnt + 8'h01 >= bkr_delay_ms(r.conv[i].dly)) begin
              next_r.conv[i].phase = BKR_RAMP;
            end
          end else begin
            next_r.conv[i].tick = r.conv[i].tick + CNT_W'(1);
          end
        end
        BKR_RAMP: begin
          // fixed-rate steps keep the ramp length independent of code
          if (r.conv[i].tick == CNT_W'(SS_STEP_CYCLES - 1)) begin
            next_r.conv[i].tick = '0;
            next_r.conv[i].frac = r.conv[i].frac + 7'h01;
            if (r.conv[i].frac + 7'h01 == 7'(SS_STEPS)) begin
              next_r.conv[i].phase = BKR_ON;
            end
          end else begin
            next_r.conv[i].tick = r.conv[i].tick + CNT_W'(1);
          end
        end
        BKR_ON: ;
      endcase
      if (!r.conv[i].run) begin
        next_r.conv[i].phase = BKR_OFF;
        next_r.conv[i].tick = '0;
        next_r.conv[i].ms_cnt = '0;
        next_r.conv[i].frac = '0;
      end
      final_mv = bkr_code_mv(next_r.conv[i].code);
      prod = {7'h00, final_mv} * {12'h000, next_r.conv[i].frac};
      next_r.conv[i].out.power_on = (next_r.conv[i].phase == BKR_RAMP) || (next_r.conv[i].phase == BKR_ON);
      unique case (next_r.conv[i].phase)
        BKR_ON: next_r.conv[i].out.target_mv = final_mv;
        BKR_RAMP: next_r.conv[i].out.target_mv = prod[17:6];
        default: next_r.conv[i].out.target_mv = '0;
      endcase
      // light-load saving only with mode 0
      next_r.conv[i].out.pwm_forced = next_r.conv[i].mode;
      next_r.conv[i].out.light_save = next_r.conv[i].out.power_on && !next_r.conv[i].mode && sense[i].light_load;
      next_r.conv[i].out.high_side_hold = next_r.conv[i].out.power_on && sense[i].dropout;
      any_alert = any_alert | next_r.conv[i].alert;
    end
    next_r.alert_n = ~any_alert;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r <= '0;
      r.alert_n <= 1'b1;
      for (int j = 0; j < NUM_CONV; j++) begin
        r.conv[j].run <= RST_RUN;
        r.conv[j].mode <= RST_MODE;
        r.conv[j].dly <= RST_DLY;
        r.conv[j].unmask <= RST_UNMASK;
        r.conv[j].code <= RST_CODE;
        r.conv[j].phase <= BKR_OFF;
      end
    end else begin
      r <= next_r;
    end
  end

  for (genvar g = 0; g < NUM_CONV; g++) begin : g_chk
    alert_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      r.conv[g].unmask && sense[g].below_pg |=> r.conv[g].alert && !host_alert_n)
      else $error("unmasked fault did not raise alert");
    alert_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      r.conv[g].alert && !(rd && addr == {2'(g), REG_STAT}) |=> r.conv[g].alert)
      else $error("alert dropped without status read");
    pg_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      sense[g].below_pg |=> !r.conv[g].pg)
      else $error("power good set while below threshold");
    run_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !r.conv[g].run |=> r.conv[g].phase == BKR_OFF && !conv_out[g].power_on)
      else $error("converter on with run bit clear");
    zero_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
      r.conv[g].phase == BKR_OFF && r.conv[g].run && r.conv[g].dly == 3'h0 |=> r.conv[g].phase == BKR_RAMP)
      else $error("zero delay did not start ramp at once");
    delay_seq_a: assert property (@(posedge clk) disable iff (!reset_n)
      r.conv[g].phase == BKR_DELAY |-> r.conv[g].frac == 7'h00 && !conv_out[g].power_on)
      else $error("output started during turn-on delay");
    ramp_mono_a: assert property (@(posedge clk) disable iff (!reset_n)
      r.conv[g].phase == BKR_RAMP && $past(r.conv[g].phase) == BKR_RAMP && $stable(r.conv[g].code)
      |-> conv_out[g].target_mv >= $past(conv_out[g].target_mv))
      else $error("soft-start target fell");
    level_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
      r.conv[g].phase == BKR_ON |-> conv_out[g].target_mv == bkr_code_mv(r.conv[g].code))
      else $error("target does not match level code");
    mode_pwm_a: assert property (@(posedge clk) disable iff (!reset_n)
      conv_out[g].light_save |-> !r.conv[g].mode && conv_out[g].power_on)
      else $error("light-load saving with forced PWM");
    hold_on_a: assert property (@(posedge clk) disable iff (!reset_n)
      conv_out[g].high_side_hold |-> conv_out[g].power_on)
      else $error("high-side hold while converter off");
    delay_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
      r.conv[g].phase == BKR_OFF && r.conv[g].run && r.conv[g].dly != 3'h0 |=> r.conv[g].phase == BKR_DELAY)
      else $error("nonzero delay did not enter delay phase");
    pwm_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
      conv_out[g].pwm_forced == r.conv[g].mode)
      else $error("forced PWM output differs from mode bit");
    pg_good_a: assert property (@(posedge clk) disable iff (!reset_n)
      !sense[g].below_pg |=> r.conv[g].pg)
      else $error("power good clear while above threshold");
    read_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
      !rd |=> rdata == 8'h00)
      else $error("read data present without a read");
    alert_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
      r.conv[g].alert |-> !host_alert_n)
      else $error("pending alert not shown on output");
    // A fault that persists through the read re-arms the alert, so only a quiet read must clear it.
    alert_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      r.conv[g].alert && rd && addr == {2'(g), REG_STAT} && !(r.conv[g].unmask && sense[g].below_pg)
      |=> !r.conv[g].alert)
      else $error("status read did not clear alert");
  end
endmodule

// ---- sim/bkr_plant.sv ----
module bkr_plant
  import bkr_pkg::*;
(
  // Conditions requested by the bench
  input wire logic [2:0] fault,
  input wire logic [2:0] light,
  input wire logic [2:0] drop,
  // Sense lines to the controller
  output bkr_pkg::bkr_sense_t [2:0] sense
);
  timeunit 1ns;
  timeprecision 1ns;
  // Outputs follow the requests at once, so any lag seen at the ports is the controller's own.
  always_comb begin
    for (int i = 0; i < NUM_CONV; i++) begin
      sense[i] = {fault[i], light[i], drop[i]};
    end
  end
endmodule

// ---- sim/bkr_ctrl_bench.sv ----
module bkr_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import bkr_pkg::*;
  localparam int MSC = 10;
  logic clk, reset_n, wr, rd, host_alert_n;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [2:0] fault, light, drop;
  bkr_sense_t [2:0] sense;
  bkr_conv_out_t [2:0] co;
  int bad_count, checks_done, cyc, n, lo;
  logic [11:0] prev;
  bkr_ctrl #(.MS_CYCLES(MSC)) i_bkr_ctrl(.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sense(sense), .conv_out(co), .host_alert_n(host_alert_n));
  bkr_plant i_bkr_plant(.fault(fault), .light(light), .drop(drop), .sense(sense));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The whole run needs about 45000 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic waitc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  function automatic logic [15:0] mv(input int c);
    int r = c / 8;
    int b = r < 3 ? 600 + 200 * r : r < 6 ? 1200 + 400 * (r - 3) : 2400 + 800 * (r - 6);
    int s = r < 3 ? 25 : r < 6 ? 50 : 100;
    return 16'(b + s * (c % 8));
  endfunction
  initial begin
    {cyc, bad_count, checks_done} = '0;
    {reset_n, wr, rd, addr, wdata, fault, light, drop} = '0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rreg(4'(i * 4 + 1), 8'h00);
    end
    chk(co[0] | co[1] | co[2], 16'h0000);
    rreg(4'hC, 8'h00);
    @(posedge clk) fault[2] <= 1'b1;
    waitc(3);
    chk(16'(host_alert_n), 16'h1);
    rreg(4'hA, 8'h00);
    for (int d = 0; d < 8; d++) begin
      lo = d == 0 ? 1 : (1 << d) * MSC;
      wreg(4'h5, 8'(d * 4 + 1));
      n = 0;
      while (co[1].power_on !== 1'b1 && n < 2000) begin
        waitc(1);
        n++;
      end
      chk(16'(n >= lo && n <= lo + 4), 16'h1);
      wreg(4'h5, 8'(d * 4));
      waitc(2);
      chk(co[1], 16'h0000);
    end
    wreg(4'h5, 8'h1D);
    waitc(100);
    wreg(4'h5, 8'h1C);
    waitc(1400);
    chk(16'(co[1].power_on), 16'h0);
    wreg(4'h0, 8'h3F);
    wreg(4'h1, 8'h01);
    waitc(2);
    chk({3'h0, co[0].power_on, co[0].target_mv}, 16'h1000);
    n = 0;
    prev = '0;
    for (int k = 0; k < 40100; k++) begin
      waitc(1);
      n += int'(co[0].target_mv < prev);
      n += int'(k == 20000 && (co[0].target_mv == 0 || co[0].target_mv >= 12'hF3C));
      prev = co[0].target_mv;
    end
    chk(16'(n), 16'h0);
    for (int c = 0; c < 64; c++) begin
      wreg(4'h0, 8'(c));
      waitc(2);
      chk(16'(co[0].target_mv), mv(c));
    end
    @(posedge clk) light[0] <= 1'b1;
    drop[0] <= 1'b1;
    waitc(3);
    chk(16'(co[0][15:12]), 16'hB);
    wreg(4'h1, 8'h03);
    waitc(2);
    chk(16'(co[0][15:12]), 16'hD);
    wreg(4'h1, 8'h23);
    @(posedge clk) fault[0] <= 1'b1;
    waitc(3);
    chk(16'(host_alert_n), 16'h0);
    rreg(4'h2, 8'h06);
    @(posedge clk) fault[0] <= 1'b0;
    waitc(5);
    chk(16'(host_alert_n), 16'h0);
    rreg(4'h2, 8'h07);
    waitc(2);
    chk(16'(host_alert_n), 16'h1);
    tally_and_finish;
  end
endmodule
